// File: hw/tmr_timer_regs.sv
// 8-bit timer with two compare channels, async source and apb registers
//
// Design decision made here: the APB register port.

module tmr_timer_regs (
	input wire logic I_CLK, // 250 MHz core clock
	input wire logic I_RST, // synchronous reset, high
	input wire logic I_PSEL, // apb select
	input wire logic I_PENABLE, // apb enable
	input wire logic I_PWRITE, // apb direction
	input wire logic [tmr_pkg::ADDR_W-1:0] I_PADDR, // apb byte address
	input wire logic [31:0] I_PWDATA, // apb write data
	output logic [31:0] O_PRDATA, // apb read data
	output logic O_PREADY, // apb ready
	output logic O_PSLVERR, // apb error, unmapped
	input wire logic I_OSC_IN, // oscillator input pin
	input wire logic I_GLOBAL_IRQ_EN, // cpu global interrupt enable
	input wire logic [2:0] I_VECTOR_ACK, // handler vectored, per source
	output logic [2:0] O_IRQ_REQ, // interrupt requests
	output logic O_WAVE_OUT_A, // waveform a
	output logic O_WAVE_OUT_A_EN, // waveform a connected
	output logic O_WAVE_OUT_B, // waveform b
	output logic O_WAVE_OUT_B_EN, // waveform b connected
	output logic O_XTAL_OSC_EN, // crystal oscillator run
	output logic O_EXT_CLK_BUF_EN // external clock buffer on
);

	// ************************************************************
	// apb decode
	// ************************************************************
	logic [7:0] idx;
	logic addr_ok;
	logic setup;
	logic wr;
	logic [7:0] wb;
	logic wr_flags;
	logic wr_mask;
	logic wr_ctl_a;
	logic wr_ctl_b;
	logic wr_cnt;
	logic wr_cmp_a;
	logic wr_cmp_b;
	logic wr_asr;

	assign idx = I_PADDR[9:2];
	assign addr_ok = (I_PADDR[1:0] == 2'h0) && (I_PADDR[tmr_pkg::ADDR_W-1:10] == 2'h0) &&
		(idx == tmr_pkg::IDX_IRQ_FLAGS || idx == tmr_pkg::IDX_IRQ_MASK ||
		idx == tmr_pkg::IDX_CONTROL_A || idx == tmr_pkg::IDX_CONTROL_B ||
		idx == tmr_pkg::IDX_COUNT_VALUE || idx == tmr_pkg::IDX_COMPARE_A ||
		idx == tmr_pkg::IDX_COMPARE_B || idx == tmr_pkg::IDX_ASYNC_STATUS);
	assign setup = I_PSEL & ~I_PENABLE;
	assign wr = I_PSEL & I_PENABLE & I_PWRITE & addr_ok;
	assign wb = I_PWDATA[7:0];
	assign wr_flags = wr && idx == tmr_pkg::IDX_IRQ_FLAGS;
	assign wr_mask = wr && idx == tmr_pkg::IDX_IRQ_MASK;
	assign wr_ctl_a = wr && idx == tmr_pkg::IDX_CONTROL_A;
	assign wr_ctl_b = wr && idx == tmr_pkg::IDX_CONTROL_B;
	assign wr_cnt = wr && idx == tmr_pkg::IDX_COUNT_VALUE;
	assign wr_cmp_a = wr && idx == tmr_pkg::IDX_COMPARE_A;
	assign wr_cmp_b = wr && idx == tmr_pkg::IDX_COMPARE_B;
	assign wr_asr = wr && idx == tmr_pkg::IDX_ASYNC_STATUS;

	// ************************************************************
	// registers
	// ************************************************************
	logic [7:0] ctl_a_q;
	logic [7:0] ctl_a_h_q;
	logic [3:0] ctl_b_q;
	logic [3:0] ctl_b_h_q;
	logic [7:0] cmp_a_q;
	logic [7:0] cmp_a_h_q;
	logic [7:0] cmp_b_q;
	logic [7:0] cmp_b_h_q;
	logic [7:0] cnt_q;
	logic [7:0] cnt_d;
	logic [7:0] cnt_h_q;
	logic [2:0] mask_q;
	logic [2:0] flags_q;
	logic [2:0] flags_d;
	logic ext_q;
	logic async_q;
	logic [4:0] busy_q;
	logic [4:0] busy_d;
	logic up_q;
	logic up_d;
	logic block_q;

	// ************************************************************
	// timer source and prescaler
	// ************************************************************
	// pin is foreign to I_CLK: two flops, then edge taken after them
	logic osc_s1_q;
	logic osc_s2_q;
	logic osc_s3_q;
	logic src_tick;
	logic [tmr_pkg::PRESCALE_W-1:0] pre_q;
	logic timer_tick;
	logic [2:0] clk_sel;

	assign src_tick = async_q ? (osc_s2_q & ~osc_s3_q) : 1'b1;
	assign clk_sel = ctl_b_q[2:0];

	assign timer_tick = (clk_sel == tmr_pkg::CS_DIV1) ? src_tick :
		(clk_sel == tmr_pkg::CS_DIV8) ? src_tick & (&pre_q[2:0]) :
		(clk_sel == tmr_pkg::CS_DIV32) ? src_tick & (&pre_q[4:0]) :
		(clk_sel == tmr_pkg::CS_DIV64) ? src_tick & (&pre_q[5:0]) :
		(clk_sel == tmr_pkg::CS_DIV128) ? src_tick & (&pre_q[6:0]) :
		(clk_sel == tmr_pkg::CS_DIV256) ? src_tick & (&pre_q[7:0]) :
		(clk_sel == tmr_pkg::CS_DIV1024) ? src_tick & (&pre_q[9:0]) : 1'b0;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			osc_s1_q <= 1'b0;
			osc_s2_q <= 1'b0;
			osc_s3_q <= 1'b0;
			pre_q <= '0;
		end else begin
			osc_s1_q <= I_OSC_IN;
			osc_s2_q <= osc_s1_q;
			osc_s3_q <= osc_s2_q;
			if (src_tick) begin
				pre_q <= pre_q + 1'b1;
			end
		end
	end

	// ************************************************************
	// mode decode
	// ************************************************************
	logic [2:0] wgm;
	tmr_pkg::tmr_mode_t mode;
	logic [7:0] top_val;
	logic pwm;

	assign wgm = {ctl_b_q[tmr_pkg::CTLB_WAVE_HIGH], ctl_a_q[1:0]};

	always_comb begin
		case (wgm)
			3'h1, 3'h5: mode = tmr_pkg::TMR_PC_PWM;
			3'h2: mode = tmr_pkg::TMR_CTC;
			3'h3, 3'h7: mode = tmr_pkg::TMR_FAST_PWM;
			default: mode = tmr_pkg::TMR_NORMAL;
		endcase
	end

	assign top_val = (wgm[2] || mode == tmr_pkg::TMR_CTC) ? cmp_a_q : tmr_pkg::COUNT_MAX;
	assign pwm = (mode == tmr_pkg::TMR_PC_PWM) || (mode == tmr_pkg::TMR_FAST_PWM);

	// ************************************************************
	// counter engine
	// ************************************************************
	logic at_top;
	logic at_bot;
	logic ovf_evt;
	logic bot_evt;
	logic match_a;
	logic match_b;
	logic force_a;
	logic force_b;
	logic cnt_load;

	assign at_top = cnt_q == top_val;
	assign at_bot = cnt_q == tmr_pkg::COUNT_BOTTOM;
	assign cnt_load = src_tick & busy_q[tmr_pkg::ASR_CNT_BUSY];

	always_comb begin
		cnt_d = cnt_q;
		up_d = up_q;
		ovf_evt = 1'b0;
		if (timer_tick) begin
			case (mode)
				tmr_pkg::TMR_PC_PWM: begin
					if (up_q) begin
						up_d = ~at_top;
						cnt_d = at_top ? cnt_q - 8'h01 : cnt_q + 8'h01;
					end else begin
						up_d = at_bot;
						ovf_evt = at_bot;
						cnt_d = at_bot ? cnt_q + 8'h01 : cnt_q - 8'h01;
					end
				end
				tmr_pkg::TMR_CTC: begin
					ovf_evt = cnt_q == tmr_pkg::COUNT_MAX;
					cnt_d = at_top ? tmr_pkg::COUNT_BOTTOM : cnt_q + 8'h01;
				end
				tmr_pkg::TMR_FAST_PWM: begin
					ovf_evt = at_top;
					cnt_d = at_top ? tmr_pkg::COUNT_BOTTOM : cnt_q + 8'h01;
				end
				default: begin
					ovf_evt = cnt_q == tmr_pkg::COUNT_MAX;
					cnt_d = cnt_q + 8'h01;
				end
			endcase
		end
	end

	assign bot_evt = timer_tick & (mode == tmr_pkg::TMR_FAST_PWM) & at_top;
	assign match_a = timer_tick & ~block_q & (cnt_q == cmp_a_q);
	assign match_b = timer_tick & ~block_q & (cnt_q == cmp_b_q);
	assign force_a = wr_ctl_b & wb[tmr_pkg::CTLB_FORCE_A] & ~pwm;
	assign force_b = wr_ctl_b & wb[tmr_pkg::CTLB_FORCE_B] & ~pwm;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			cnt_q <= tmr_pkg::RST_BYTE;
			up_q <= 1'b1;
			block_q <= 1'b0;
		end else begin
			up_q <= up_d;
			if (wr_cnt && !async_q) begin
				cnt_q <= wb;
			end else if (cnt_load) begin
				cnt_q <= cnt_h_q;
			end else begin
				cnt_q <= cnt_d;
			end
			if ((wr_cnt && !async_q) || cnt_load) begin
				block_q <= 1'b1;
			end else if (timer_tick) begin
				block_q <= 1'b0;
			end
		end
	end

	// ************************************************************
	// compare and control registers with holding copies
	// ************************************************************
	// busy set on async write
	always_comb begin
		busy_d = busy_q;
		if (src_tick) begin
			busy_d = 5'h00;
		end
		if (async_q) begin
			busy_d[tmr_pkg::ASR_CNT_BUSY] = busy_d[tmr_pkg::ASR_CNT_BUSY] | wr_cnt;
			busy_d[tmr_pkg::BUSY_CMP_A] = busy_d[tmr_pkg::BUSY_CMP_A] | wr_cmp_a;
			busy_d[tmr_pkg::BUSY_CMP_B] = busy_d[tmr_pkg::BUSY_CMP_B] | wr_cmp_b;
			busy_d[tmr_pkg::BUSY_CTL_A] = busy_d[tmr_pkg::BUSY_CTL_A] | wr_ctl_a;
			busy_d[tmr_pkg::BUSY_CTL_B] = busy_d[tmr_pkg::BUSY_CTL_B] | wr_ctl_b;
		end
		if (wr_asr && (wb[tmr_pkg::ASR_ASYNC_SEL] != async_q)) begin
			busy_d = 5'h00;
		end
	end

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ctl_a_h_q <= tmr_pkg::RST_BYTE;
			ctl_b_h_q <= 4'h0;
			cmp_a_h_q <= tmr_pkg::RST_BYTE;
			cmp_b_h_q <= tmr_pkg::RST_BYTE;
			cnt_h_q <= tmr_pkg::RST_BYTE;
			busy_q <= 5'h00;
		end else begin
			busy_q <= busy_d;
			if (wr_ctl_a) begin
				ctl_a_h_q <= {wb[7:4], 2'h0, wb[1:0]};
			end
			if (wr_ctl_b) begin
				ctl_b_h_q <= wb[3:0];
			end
			if (wr_cmp_a) begin
				cmp_a_h_q <= wb;
			end
			if (wr_cmp_b) begin
				cmp_b_h_q <= wb;
			end
			if (wr_cnt) begin
				cnt_h_q <= wb;
			end
		end
	end

	// live copies follow writes at once when synchronous, else on a source tick
	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			ctl_a_q <= tmr_pkg::RST_BYTE;
			ctl_b_q <= 4'h0;
			cmp_a_q <= tmr_pkg::RST_BYTE;
			cmp_b_q <= tmr_pkg::RST_BYTE;
		end else begin
			if (wr_ctl_a && !async_q) begin
				ctl_a_q <= {wb[7:4], 2'h0, wb[1:0]};
			end else if (src_tick && busy_q[tmr_pkg::BUSY_CTL_A]) begin
				ctl_a_q <= ctl_a_h_q;
			end
			if (wr_ctl_b && !async_q) begin
				ctl_b_q <= wb[3:0];
			end else if (src_tick && busy_q[tmr_pkg::BUSY_CTL_B]) begin
				ctl_b_q <= ctl_b_h_q;
			end
			if (wr_cmp_a && !async_q) begin
				cmp_a_q <= wb;
			end else if (src_tick && busy_q[tmr_pkg::BUSY_CMP_A]) begin
				cmp_a_q <= cmp_a_h_q;
			end
			if (wr_cmp_b && !async_q) begin
				cmp_b_q <= wb;
			end else if (src_tick && busy_q[tmr_pkg::BUSY_CMP_B]) begin
				cmp_b_q <= cmp_b_h_q;
			end
		end
	end

	// ************************************************************
	// flags, mask, clock status, interrupt requests
	// ************************************************************
	logic [2:0] flag_set;
	logic [2:0] flag_clr;

	assign flag_set = {match_b, match_a, ovf_evt};
	assign flag_clr = I_VECTOR_ACK | ({3{wr_flags}} & wb[2:0]);
	// a new event in the clearing cycle survives
	assign flags_d = (flags_q & ~flag_clr) | flag_set;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			flags_q <= 3'h0;
			mask_q <= 3'h0;
			ext_q <= 1'b0;
			async_q <= 1'b0;
			O_IRQ_REQ <= 3'h0;
			O_XTAL_OSC_EN <= 1'b0;
			O_EXT_CLK_BUF_EN <= 1'b0;
		end else begin
			flags_q <= flags_d;
			if (wr_mask) begin
				mask_q <= wb[2:0];
			end
			if (wr_asr) begin
				ext_q <= wb[tmr_pkg::ASR_EXT_CLK];
				async_q <= wb[tmr_pkg::ASR_ASYNC_SEL];
			end
			O_IRQ_REQ <= mask_q & flags_q & {3{I_GLOBAL_IRQ_EN}};
			O_XTAL_OSC_EN <= async_q & ~ext_q;
			O_EXT_CLK_BUF_EN <= async_q & ext_q;
		end
	end

	// ************************************************************
	// waveform units
	// ************************************************************
	tmr_chan_if ch_a ();
	tmr_chan_if ch_b ();

	assign ch_a.mode = mode;
	assign ch_a.action = ctl_a_q[tmr_pkg::CTLA_ACTION_A_LSB+:2];
	assign ch_a.match = match_a;
	assign ch_a.force_match = force_a;
	assign ch_a.bottom = bot_evt;
	assign ch_a.up_count = up_q;
	assign ch_a.toggle_ok = wgm[2];
	assign ch_b.mode = mode;
	assign ch_b.action = ctl_a_q[tmr_pkg::CTLA_ACTION_B_LSB+:2];
	assign ch_b.match = match_b;
	assign ch_b.force_match = force_b;
	assign ch_b.bottom = bot_evt;
	assign ch_b.up_count = up_q;
	// channel b has no toggle setting in PWM
	assign ch_b.toggle_ok = 1'b0;

	tmr_wave_unit u_wave_a (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.ch(ch_a)
	);

	tmr_wave_unit u_wave_b (
		.i_clk(I_CLK),
		.i_rst(I_RST),
		.ch(ch_b)
	);

	assign O_WAVE_OUT_A = ch_a.wave;
	assign O_WAVE_OUT_B = ch_b.wave;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_WAVE_OUT_A_EN <= 1'b0;
			O_WAVE_OUT_B_EN <= 1'b0;
		end else begin
			O_WAVE_OUT_A_EN <= ctl_a_q[tmr_pkg::CTLA_ACTION_A_LSB+:2] != 2'h0;
			O_WAVE_OUT_B_EN <= ctl_a_q[tmr_pkg::CTLA_ACTION_B_LSB+:2] != 2'h0;
		end
	end

	// ************************************************************
	// apb read path, answered without wait states
	// ************************************************************
	logic [7:0] rsel;

	assign rsel = (idx == tmr_pkg::IDX_IRQ_FLAGS) ? {5'h00, flags_q} :
		(idx == tmr_pkg::IDX_IRQ_MASK) ? {5'h00, mask_q} :
		(idx == tmr_pkg::IDX_CONTROL_A) ? ctl_a_h_q :
		(idx == tmr_pkg::IDX_CONTROL_B) ? {4'h0, ctl_b_h_q} :
		(idx == tmr_pkg::IDX_COUNT_VALUE) ? cnt_q :
		(idx == tmr_pkg::IDX_COMPARE_A) ? cmp_a_h_q :
		(idx == tmr_pkg::IDX_COMPARE_B) ? cmp_b_h_q :
		(idx == tmr_pkg::IDX_ASYNC_STATUS) ? {1'b0, ext_q, async_q, busy_q} : 8'h00;

	always_ff @(posedge I_CLK) begin
		if (I_RST) begin
			O_PRDATA <= 32'h00000000;
			O_PREADY <= 1'b0;
			O_PSLVERR <= 1'b0;
		end else begin
			O_PREADY <= 1'b1;
			if (setup) begin
				O_PRDATA <= (addr_ok && !I_PWRITE) ? {24'h000000, rsel} : 32'h00000000;
				O_PSLVERR <= ~addr_ok;
			end
		end
	end

endmodule : tmr_timer_regs

// File: hw/tmr_pkg.sv
// constants and types shared by the timer register block
package tmr_pkg;

	// ************************************************************
	// register indices, byte address is four times the index
	// ************************************************************
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'h37;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h70;
	localparam logic [7:0] IDX_CONTROL_A = 8'hb0;
	localparam logic [7:0] IDX_CONTROL_B = 8'hb1;
	localparam logic [7:0] IDX_COUNT_VALUE = 8'hb2;
	localparam logic [7:0] IDX_COMPARE_A = 8'hb3;
	localparam logic [7:0] IDX_COMPARE_B = 8'hb4;
	localparam logic [7:0] IDX_ASYNC_STATUS = 8'hb6;
	localparam int ADDR_W = 12;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTLB_FORCE_A = 7;
	localparam int CTLB_FORCE_B = 6;
	localparam int CTLB_WAVE_HIGH = 3;
	localparam int CTLA_ACTION_A_LSB = 6;
	localparam int CTLA_ACTION_B_LSB = 4;
	localparam int ASR_EXT_CLK = 6;
	localparam int ASR_ASYNC_SEL = 5;
	localparam int ASR_CNT_BUSY = 4;
	localparam int BUSY_CMP_A = 3;
	localparam int BUSY_CMP_B = 2;
	localparam int BUSY_CTL_A = 1;
	localparam int BUSY_CTL_B = 0;
	localparam int IRQ_MATCH_B = 2;
	localparam int IRQ_MATCH_A = 1;
	localparam int IRQ_OVERFLOW = 0;

	// ************************************************************
	// reset values and counter limits
	// ************************************************************
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	localparam logic [7:0] COUNT_BOTTOM = 8'h00;
	localparam int PRESCALE_W = 10;

	// ************************************************************
	// clock select codes
	// ************************************************************
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV32 = 3'h3;
	localparam logic [2:0] CS_DIV64 = 3'h4;
	localparam logic [2:0] CS_DIV128 = 3'h5;
	localparam logic [2:0] CS_DIV256 = 3'h6;
	localparam logic [2:0] CS_DIV1024 = 3'h7;

	typedef enum logic [1:0] {TMR_NORMAL, TMR_PC_PWM, TMR_CTC, TMR_FAST_PWM} tmr_mode_t;

endpackage : tmr_pkg

// File: hw/tmr_chan_if.sv
// signals between the counter core and one waveform unit
interface tmr_chan_if;
	tmr_pkg::tmr_mode_t mode;
	logic [1:0] action;
	logic match;
	logic force_match;
	logic bottom;
	logic up_count;
	logic toggle_ok;
	logic wave;

	modport core (output mode, output action, output match, output force_match, output bottom,
		output up_count, output toggle_ok, input wave);
	modport unit (input mode, input action, input match, input force_match, input bottom,
		input up_count, input toggle_ok, output wave);
endinterface : tmr_chan_if

// File: hw/tmr_wave_unit.sv
// waveform output flip-flop of one compare channel
module tmr_wave_unit (
	input wire logic i_clk, // core clock
	input wire logic i_rst, // synchronous reset
	tmr_chan_if.unit ch // channel controls
);
	logic wave_q;
	logic wave_d;
	logic hit;
	logic bot;

	assign hit = ch.match | ch.force_match;
	assign bot = ch.bottom;
	assign ch.wave = wave_q;

	always_comb begin
		wave_d = wave_q;
		case (ch.mode)
			tmr_pkg::TMR_NORMAL, tmr_pkg::TMR_CTC: begin
				if (hit) begin
					case (ch.action)
						2'h1: wave_d = ~wave_q;
						2'h2: wave_d = 1'b0;
						2'h3: wave_d = 1'b1;
						default: wave_d = wave_q;
					endcase
				end
			end
			tmr_pkg::TMR_FAST_PWM: begin
				if (ch.match) begin
					case (ch.action)
						2'h1: wave_d = ch.toggle_ok ? ~wave_q : wave_q;
						2'h2: wave_d = 1'b0;
						2'h3: wave_d = 1'b1;
						default: wave_d = wave_q;
					endcase
				end else if (bot) begin
					case (ch.action)
						2'h2: wave_d = 1'b1;
						2'h3: wave_d = 1'b0;
						default: wave_d = wave_q;
					endcase
				end
			end
			tmr_pkg::TMR_PC_PWM: begin
				if (ch.match) begin
					case (ch.action)
						2'h1: wave_d = ch.toggle_ok ? ~wave_q : wave_q;
						2'h2: wave_d = ~ch.up_count;
						2'h3: wave_d = ch.up_count;
						default: wave_d = wave_q;
					endcase
				end
			end
			default: wave_d = wave_q;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wave_q <= 1'b0;
		end else begin
			wave_q <= wave_d;
		end
	end

endmodule : tmr_wave_unit

// File: verification/tmr_timer_regs_asserts.sv
// concurrent checks on the ports of the timer register block
module tmr_timer_regs_asserts (
	input wire logic I_CLK, // clock
	input wire logic I_RST, // reset
	input wire logic I_PSEL, // select
	input wire logic I_PENABLE, // enable
	input wire logic I_PWRITE, // direction
	input wire logic [tmr_pkg::ADDR_W-1:0] I_PADDR, // address
	input wire logic [31:0] I_PWDATA, // write data
	input wire logic [31:0] O_PRDATA, // read data
	input wire logic O_PREADY, // ready
	input wire logic O_PSLVERR, // error
	input wire logic I_OSC_IN, // osc pin
	input wire logic I_GLOBAL_IRQ_EN, // global enable
	input wire logic [2:0] I_VECTOR_ACK, // vector ack
	input wire logic [2:0] O_IRQ_REQ, // requests
	input wire logic O_WAVE_OUT_A, // wave a
	input wire logic O_WAVE_OUT_A_EN, // wave a on
	input wire logic O_WAVE_OUT_B, // wave b
	input wire logic O_WAVE_OUT_B_EN, // wave b on
	input wire logic O_XTAL_OSC_EN, // crystal run
	input wire logic O_EXT_CLK_BUF_EN // ext buffer
);
	// ****************************************
	// access decode
	// ****************************************
	localparam logic [11:0] A_MASK = {2'h0, tmr_pkg::IDX_IRQ_MASK, 2'h0};
	localparam logic [11:0] A_CTLA = {2'h0, tmr_pkg::IDX_CONTROL_A, 2'h0};
	localparam logic [11:0] A_CTLB = {2'h0, tmr_pkg::IDX_CONTROL_B, 2'h0};
	localparam logic [11:0] A_ASR = {2'h0, tmr_pkg::IDX_ASYNC_STATUS, 2'h0};
	wire logic acc = I_PSEL && I_PENABLE;
	wire logic rd_acc = acc && !I_PWRITE;
	// async writes land later, so only sync writes are timed, except status register writes, timed in any mode
	wire logic wr_sync = acc && I_PWRITE && !O_XTAL_OSC_EN && !O_EXT_CLK_BUF_EN;
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_RST);
	// ****************************************
	// properties
	// ****************************************
	irq_gate_a: assert property (!I_GLOBAL_IRQ_EN |=> O_IRQ_REQ == 3'h0)
		else $error("request without global enable");
	mask_off_a: assert property (wr_sync && I_PADDR == A_MASK && I_PWDATA[2:0] == 3'h0 |=> ##1 O_IRQ_REQ == 3'h0)
		else $error("request after mask cleared");
	mask_rd_a: assert property (rd_acc && I_PADDR == A_MASK |-> O_PRDATA[7:3] == 5'h0)
		else $error("mask reserved bits set");
	force_rd_a: assert property (rd_acc && I_PADDR == A_CTLB |-> O_PRDATA[7:4] == 4'h0)
		else $error("force or reserved bits read back");
	asr_rd_a: assert property (rd_acc && I_PADDR == A_ASR |-> !O_PRDATA[7])
		else $error("status bit 7 set");
	wave_en_a_a: assert property (wr_sync && I_PADDR == A_CTLA |-> ##2 O_WAVE_OUT_A_EN == ($past(I_PWDATA[7:6], 2) != 2'h0))
		else $error("wave a enable wrong");
	wave_en_b_a: assert property (wr_sync && I_PADDR == A_CTLA |-> ##2 O_WAVE_OUT_B_EN == ($past(I_PWDATA[5:4], 2) != 2'h0))
		else $error("wave b enable wrong");
	ext_buf_a: assert property (acc && I_PWRITE && I_PADDR == A_ASR |-> ##2 O_EXT_CLK_BUF_EN == &$past(I_PWDATA[6:5], 2))
		else $error("ext buffer enable wrong");
	xtal_run_a: assert property (acc && I_PWRITE && I_PADDR == A_ASR |-> ##2 O_XTAL_OSC_EN == ($past(I_PWDATA[6:5], 2) == 2'h1))
		else $error("crystal enable wrong");
endmodule : tmr_timer_regs_asserts

bind tmr_timer_regs tmr_timer_regs_asserts chk_u (.I_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA,
	.O_PRDATA, .O_PREADY, .O_PSLVERR, .I_OSC_IN, .I_GLOBAL_IRQ_EN, .I_VECTOR_ACK, .O_IRQ_REQ, .O_WAVE_OUT_A,
	.O_WAVE_OUT_A_EN, .O_WAVE_OUT_B, .O_WAVE_OUT_B_EN, .O_XTAL_OSC_EN, .O_EXT_CLK_BUF_EN);

// File: verification/tb.sv
// self-checking bench for the timer register block
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic I_CLK, I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_OSC_IN, I_GLOBAL_IRQ_EN;
	logic [11:0] I_PADDR;
	logic [31:0] I_PWDATA, O_PRDATA, rd_q;
	logic [2:0] I_VECTOR_ACK, O_IRQ_REQ;
	logic O_PREADY, O_PSLVERR, O_WAVE_OUT_A, O_WAVE_OUT_A_EN, O_WAVE_OUT_B, O_WAVE_OUT_B_EN;
	logic O_XTAL_OSC_EN, O_EXT_CLK_BUF_EN, err_q;
	int n_mismatch, compares, cyc;
	tmr_timer_regs dut_u (.I_CLK, .I_RST, .I_PSEL, .I_PENABLE, .I_PWRITE, .I_PADDR, .I_PWDATA, .O_PRDATA,
		.O_PREADY, .O_PSLVERR, .I_OSC_IN, .I_GLOBAL_IRQ_EN, .I_VECTOR_ACK, .O_IRQ_REQ, .O_WAVE_OUT_A,
		.O_WAVE_OUT_A_EN, .O_WAVE_OUT_B, .O_WAVE_OUT_B_EN, .O_XTAL_OSC_EN, .O_EXT_CLK_BUF_EN);
	// ****************************************
	// bus and compare helpers
	// ****************************************
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	// one apb transfer, then one idle cycle so no signal is driven twice per step
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] d);
		I_PSEL <= 1'b1;
		I_PWRITE <= w;
		I_PADDR <= {2'h0, idx, 2'h0};
		I_PWDATA <= {24'h0, d};
		@(posedge I_CLK);
		I_PENABLE <= 1'b1;
		do @(posedge I_CLK); while (O_PREADY !== 1'b1);
		rd_q = O_PRDATA;
		err_q = O_PSLVERR;
		I_PSEL <= 1'b0;
		I_PENABLE <= 1'b0;
		@(posedge I_CLK);
	endtask : xfer
	task automatic wr(input logic [7:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d);
	endtask : wr
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 8'h00);
		chk(rd_q, exp);
	endtask : rd
	task automatic osc_tick;
		I_OSC_IN <= 1'b1;
		repeat (6) @(posedge I_CLK);
		I_OSC_IN <= 1'b0;
		repeat (6) @(posedge I_CLK);
	endtask : osc_tick
	// ****************************************
	// scenarios
	// ****************************************
	// reset values and read masks
	task automatic t_regs;
		rd(tmr_pkg::IDX_IRQ_MASK, 32'h0);
		rd(tmr_pkg::IDX_CONTROL_B, 32'h0);
		rd(tmr_pkg::IDX_ASYNC_STATUS, 32'h0);
		wr(tmr_pkg::IDX_IRQ_MASK, 8'hff);
		rd(tmr_pkg::IDX_IRQ_MASK, 32'h7);
		wr(tmr_pkg::IDX_CONTROL_B, 8'hf8);
		rd(tmr_pkg::IDX_CONTROL_B, 32'h8);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		wr(tmr_pkg::IDX_ASYNC_STATUS, 8'h80);
		rd(tmr_pkg::IDX_ASYNC_STATUS, 32'h0);
		xfer(1'b0, 8'h01, 8'h00);
		chk({rd_q[30:0], err_q}, 32'h1);
	endtask : t_regs
	// every divider tap gives four ticks in four periods
	task automatic t_clk;
		int div[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
		for (int cs = 1; cs < 8; cs++) begin
			wr(tmr_pkg::IDX_CONTROL_B, 8'(cs));
			wr(tmr_pkg::IDX_COUNT_VALUE, 8'h00);
			repeat (4 * div[cs] - 1) @(posedge I_CLK);
			xfer(1'b0, tmr_pkg::IDX_COUNT_VALUE, 8'h00);
			chk(32'(rd_q inside {[3:5]}), 32'h1);
		end
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'h00);
		repeat (20) @(posedge I_CLK);
		rd(tmr_pkg::IDX_COUNT_VALUE, 32'h0);
	endtask : t_clk
	task automatic t_ovf;
		wr(tmr_pkg::IDX_COMPARE_A, 8'h02);
		wr(tmr_pkg::IDX_COMPARE_B, 8'h03);
		wr(tmr_pkg::IDX_IRQ_MASK, 8'h01);
		I_GLOBAL_IRQ_EN <= 1'b1;
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'hf8);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h01);
		repeat (20) @(posedge I_CLK);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		chk({29'h0, O_IRQ_REQ}, 32'h1);
		wr(tmr_pkg::IDX_IRQ_FLAGS, 8'h00);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h7);
		wr(tmr_pkg::IDX_IRQ_MASK, 8'h00);
		@(posedge I_CLK);
		chk({29'h0, O_IRQ_REQ}, 32'h0);
		wr(tmr_pkg::IDX_IRQ_MASK, 8'h01);
		I_GLOBAL_IRQ_EN <= 1'b0;
		repeat (2) @(posedge I_CLK);
		chk({29'h0, O_IRQ_REQ}, 32'h0);
		wr(tmr_pkg::IDX_IRQ_FLAGS, 8'h01);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h6);
		I_VECTOR_ACK <= 3'h2;
		@(posedge I_CLK);
		I_VECTOR_ACK <= 3'h0;
		@(posedge I_CLK);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h4);
		wr(tmr_pkg::IDX_IRQ_FLAGS, 8'h04);
	endtask : t_ovf
	task automatic t_cmp;
		wr(tmr_pkg::IDX_COMPARE_A, 8'h10);
		wr(tmr_pkg::IDX_CONTROL_A, 8'h50);
		wr(tmr_pkg::IDX_CONTROL_B, 8'hc0);
		repeat (3) @(posedge I_CLK);
		chk({30'h0, O_WAVE_OUT_A, O_WAVE_OUT_B}, 32'h3);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h0);
		wr(tmr_pkg::IDX_CONTROL_A, 8'h53);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		repeat (3) @(posedge I_CLK);
		chk({30'h0, O_WAVE_OUT_A, O_WAVE_OUT_B}, 32'h3);
		wr(tmr_pkg::IDX_CONTROL_A, 8'h80);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'h20);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h01);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'h10);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h0);
		chk({31'h0, O_WAVE_OUT_A}, 32'h1);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'h0e);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h01);
		repeat (8) @(posedge I_CLK);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h2);
		chk({31'h0, O_WAVE_OUT_A}, 32'h0);
	endtask : t_cmp
	// phase-correct PWM: overflow flag only at the bottom turn
	task automatic t_pwm;
		wr(tmr_pkg::IDX_IRQ_FLAGS, 8'h07);
		wr(tmr_pkg::IDX_CONTROL_A, 8'h01);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'hfe);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h01);
		repeat (197) @(posedge I_CLK);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h0);
		rd(tmr_pkg::IDX_COUNT_VALUE, 32'h38);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h01);
		repeat (97) @(posedge I_CLK);
		wr(tmr_pkg::IDX_CONTROL_B, 8'h00);
		rd(tmr_pkg::IDX_IRQ_FLAGS, 32'h7);
		rd(tmr_pkg::IDX_COUNT_VALUE, 32'h2c);
		wr(tmr_pkg::IDX_IRQ_FLAGS, 8'h07);
		wr(tmr_pkg::IDX_CONTROL_A, 8'h00);
	endtask : t_pwm
	task automatic t_async;
		wr(tmr_pkg::IDX_ASYNC_STATUS, 8'h40);
		wr(tmr_pkg::IDX_ASYNC_STATUS, 8'h60);
		@(posedge I_CLK);
		chk({30'h0, O_EXT_CLK_BUF_EN, O_XTAL_OSC_EN}, 32'h2);
		wr(tmr_pkg::IDX_COMPARE_B, 8'h77);
		wr(tmr_pkg::IDX_COUNT_VALUE, 8'h05);
		rd(tmr_pkg::IDX_ASYNC_STATUS, 32'h74);
		rd(tmr_pkg::IDX_COMPARE_B, 32'h77);
		osc_tick();
		rd(tmr_pkg::IDX_ASYNC_STATUS, 32'h60);
		rd(tmr_pkg::IDX_COUNT_VALUE, 32'h05);
		wr(tmr_pkg::IDX_ASYNC_STATUS, 8'h20);
		@(posedge I_CLK);
		chk({30'h0, O_EXT_CLK_BUF_EN, O_XTAL_OSC_EN}, 32'h1);
	endtask : t_async
	// ****************************************
	// run control
	// ****************************************
	task automatic end_sim;
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim
	initial begin
		I_CLK = 1'b0;
		forever #2 I_CLK = ~I_CLK;
	end
	// whole run is near 6700 cycles; a stuck handshake ends here
	always @(posedge I_CLK) begin
		cyc++;
		if (cyc == 30000) begin
			n_mismatch++;
			end_sim();
		end
	end
	initial begin
		{I_RST, I_PSEL, I_PENABLE, I_PWRITE, I_OSC_IN, I_GLOBAL_IRQ_EN} = 6'h20;
		I_PADDR = 12'h000;
		I_PWDATA = 32'h0;
		I_VECTOR_ACK = 3'h0;
		repeat (20) @(posedge I_CLK);
		I_RST <= 1'b0;
		repeat (2) @(posedge I_CLK);
		t_regs();
		t_clk();
		t_ovf();
		t_cmp();
		t_pwm();
		t_async();
		end_sim();
	end
endmodule : tb
